// ### rtl/isp_core.sv
`timescale 1ns/1ps
`default_nettype none
module isp_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [isp_pkg::NPE-1:0] pin_private,
  input wire logic [isp_pkg::NSPI-1:0] pin_shared,
  input wire isp_pkg::isp_msg_t msg,
  output logic [isp_pkg::NPE-1:0] irq_out
);
  localparam int NPE = isp_pkg::NPE;
  localparam int NSRC = isp_pkg::NSRC;
  localparam int NSPI = isp_pkg::NSPI;
  localparam int NPIN = NPE + NSPI;

  logic aff_on_q, two_sec_q;
  logic [7:0] group_q;
  logic [2:0] trig_q;
  logic [15:0] route_q;
  logic [31:0] prio_q;
  logic [4:0] enable_q;
  logic [9:0] lpi_cfg_q;
  logic [7:0] pmr_q [NPE];
  logic [6:0] bpr_q [NPE];
  logic [NSRC-1:0] pend_q [NPE];
  logic [NSRC-1:0] act_q [NPE];
  logic irq_q [NPE];
  logic [7:0] rpr_w [NPE];
  logic [2:0] best_src_w [NPE];
  logic best_vld_w [NPE];
  logic [9:0] st_w [NPE];
  logic [NPIN-1:0] sync1_q, sync2_q, sync3_q, pin_f_q, pin_prev_q;
  logic [NPIN-1:0] pin_rise;
  logic [NSPI-1:0] msg_lvl_q, msg_set, msg_clr, spi_edge, spi_lvl;
  logic [NPE-1:0] tgt_w [NSPI];
  logic rr_q;
  logic [31:0] prdata_q, rd_d;
  logic err_q, ack_pe_q, ack_hit_q, first_q;
  logic [2:0] ack_src_q;
  logic setup, access, is_glob, is_pe, mapped, pe_sel, ack_do, sgi_wr, eoi_wr;
  logic [4:0] off;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [13:0] id_of(input logic [2:0] s);
    if (s == 3'(isp_pkg::S_SGI)) return isp_pkg::ID_SGI;
    else if (s == 3'(isp_pkg::S_PPI)) return isp_pkg::ID_PPI;
    else if (s == 3'(isp_pkg::S_LPI)) return isp_pkg::ID_LPI;
    else return isp_pkg::ID_SPI0 + 14'(s - 3'(isp_pkg::S_SPI0));
  endfunction

  // bus decode; one access phase, no wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign off = paddr[4:0];
  assign pe_sel = paddr[5];
  assign is_glob = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign is_pe = (paddr[11:6] == isp_pkg::PE_REGION) && (paddr[1:0] == 2'h0) && (off <= isp_pkg::O_STATE);
  assign mapped = is_glob | is_pe;
  assign pready = access;
  assign pslverr = access & err_q;
  assign prdata = prdata_q;
  assign ack_do = access & ~pwrite & is_pe & (off == isp_pkg::O_ACK) & ack_hit_q;
  // generation register write makes the software interrupt
  assign sgi_wr = access & pwrite & (paddr == isp_pkg::A_SGI_GEN);
  assign eoi_wr = access & pwrite & is_pe & (off == isp_pkg::O_EOI);

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_d = '0;
    if (paddr == isp_pkg::A_CTRL) begin
      rd_d[1:0] = {two_sec_q, aff_on_q};
    end else if (paddr == isp_pkg::A_GROUP) begin
      rd_d[7:0] = group_q;
    end else if (paddr == isp_pkg::A_TRIG) begin
      rd_d[2:0] = trig_q;
    end else if (paddr == isp_pkg::A_ROUTE) begin
      rd_d[15:0] = route_q;
    end else if (paddr == isp_pkg::A_PRIO) begin
      rd_d = prio_q;
    end else if (paddr == isp_pkg::A_ENABLE) begin
      rd_d[4:0] = enable_q;
    end else if (paddr == isp_pkg::A_LPI_CFG) begin
      rd_d[9:0] = lpi_cfg_q;
    end else if (is_pe && off == isp_pkg::O_PMR) begin
      rd_d[7:0] = pmr_q[pe_sel];
    end else if (is_pe && off == isp_pkg::O_BPR) begin
      rd_d[6:0] = bpr_q[pe_sel];
    end else if (is_pe && off == isp_pkg::O_ACK) begin
      rd_d[13:0] = best_vld_w[pe_sel] ? id_of(best_src_w[pe_sel]) : isp_pkg::ID_SPURIOUS;
    end else if (is_pe && off == isp_pkg::O_RPR) begin
      rd_d[7:0] = rpr_w[pe_sel];
    end else if (is_pe && off == isp_pkg::O_STATE) begin
      rd_d[9:0] = st_w[pe_sel];
    end
  end

  // read data, error flag and the acknowledge capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      ack_pe_q <= 1'b0;
      ack_src_q <= 3'h0;
      ack_hit_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_d;
      err_q <= ~mapped;
      ack_pe_q <= pe_sel;
      ack_src_q <= best_src_w[pe_sel];
      ack_hit_q <= best_vld_w[pe_sel] & is_pe & (off == isp_pkg::O_ACK) & ~pwrite;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {two_sec_q, aff_on_q} <= isp_pkg::CTRL_RST;
      group_q <= 8'h00;
      trig_q <= 3'h0;
      route_q <= 16'h0000;
      prio_q <= 32'h0000_0000;
      enable_q <= 5'h00;
      lpi_cfg_q <= 10'h000;
      for (int i = 0; i < NPE; i++) begin
        pmr_q[i] <= isp_pkg::PMR_RST;
        bpr_q[i] <= isp_pkg::BPR_RST;
      end
    end else if (access & pwrite) begin
      if (paddr == isp_pkg::A_CTRL) begin
        {two_sec_q, aff_on_q} <= pwdata[1:0];
      end else if (paddr == isp_pkg::A_GROUP) begin
        group_q <= pwdata[7:0];
      end else if (paddr == isp_pkg::A_TRIG) begin
        trig_q <= pwdata[2:0];
      end else if (paddr == isp_pkg::A_ROUTE) begin
        route_q <= pwdata[15:0];
      end else if (paddr == isp_pkg::A_PRIO) begin
        prio_q <= pwdata;
      end else if (paddr == isp_pkg::A_ENABLE) begin
        enable_q <= pwdata[4:0];
      end else if (paddr == isp_pkg::A_LPI_CFG) begin
        lpi_cfg_q <= pwdata[9:0];
      end else if (is_pe && off == isp_pkg::O_PMR) begin
        pmr_q[pe_sel] <= pwdata[7:0];
      end else if (is_pe && off == isp_pkg::O_BPR) begin
        bpr_q[pe_sel] <= pwdata[6:0];
      end
    end
  end

  // pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_f_q <= '0;
      pin_prev_q <= '0;
    end else begin
      sync1_q <= {pin_shared, pin_private};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_f_q <= (sync2_q & sync3_q) | (pin_f_q & (sync2_q | sync3_q));
      pin_prev_q <= pin_f_q;
    end
  end
  // rising edge of the filtered level
  assign pin_rise = pin_f_q & ~pin_prev_q;

  // shared message writes land at distributor addresses
  generate
    for (genvar j = 0; j < NSPI; j++) begin : g_spi
      assign msg_set[j] = msg.valid && msg.addr == isp_pkg::MSG_SPI_SET && msg.data[0] == 1'(j);
      assign msg_clr[j] = msg.valid && msg.addr == isp_pkg::MSG_SPI_CLR && msg.data[0] == 1'(j);
      assign spi_edge[j] = pin_rise[NPE+j] | msg_set[j];
      assign spi_lvl[j] = pin_f_q[NPE+j] | msg_lvl_q[j];
      // mode 0 picks one core; legacy target bits
      always_comb begin
        logic [NPE-1:0] set;
        set = '0;
        if (aff_on_q) begin
          if (route_q[j*isp_pkg::RT_STRIDE+isp_pkg::RT_MODE]) set = '1;
          else set[route_q[j*isp_pkg::RT_STRIDE+isp_pkg::RT_PE]] = 1'b1;
        end else begin
          set = route_q[j*isp_pkg::RT_STRIDE+isp_pkg::RT_TGT +: NPE];
        end
        // one-of-N picks a single core, rotating for fairness
        // chosen core gets it regardless of its masks
        tgt_w[j] = (set == 2'b11) ? (rr_q ? 2'b10 : 2'b01) : set;
      end
    end
  endgenerate

  // message level latch; a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msg_lvl_q <= '0;
    else msg_lvl_q <= msg_set | (msg_lvl_q & ~msg_clr);
  end

  // one-of-N rotation advances on every shared acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rr_q <= 1'b0;
    else if (ack_do && ack_src_q >= 3'(isp_pkg::S_SPI0) && ack_src_q < 3'(isp_pkg::S_LPI)) rr_q <= ~rr_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_q <= 1'b0;
    else first_q <= 1'b1;
  end

  // private, software and locality slots are per core, shared slots routed to cores by the distributor
  generate
    for (genvar p = 0; p < NPE; p++) begin : g_pe
      // locality address sits in this core's redistributor
      localparam logic [31:0] LPI_ADDR = isp_pkg::MSG_LPI_BASE + 32'(p) * isp_pkg::MSG_LPI_STRIDE;
      logic [NSRC-1:0] set_e, lvl_m, lvl, ack_s, eoi_s;
      logic [7:0] prio [NSRC];
      logic [7:0] gp [NSRC];
      logic [1:0] grp [NSRC];

      // assertion sources per slot
      always_comb begin
        set_e = '0;
        lvl_m = '0;
        lvl = '0;
        set_e[isp_pkg::S_SGI] = sgi_wr & pwdata[p];
        set_e[isp_pkg::S_PPI] = trig_q[0] & pin_rise[p];
        lvl_m[isp_pkg::S_PPI] = ~trig_q[0];
        lvl[isp_pkg::S_PPI] = pin_f_q[p];
        for (int j = 0; j < NSPI; j++) begin
          set_e[isp_pkg::S_SPI0+j] = trig_q[1+j] & spi_edge[j] & tgt_w[j][p];
          lvl_m[isp_pkg::S_SPI0+j] = ~trig_q[1+j];
          lvl[isp_pkg::S_SPI0+j] = spi_lvl[j] & tgt_w[j][p];
        end
        // locality slot raised only by its message, always edge
        // no translation path exists for the other slots
        set_e[isp_pkg::S_LPI] = msg.valid && msg.addr == LPI_ADDR;
        for (int s = 0; s < NSRC; s++) begin
          ack_s[s] = ack_do && ack_pe_q == 1'(p) && ack_src_q == 3'(s);
          eoi_s[s] = eoi_wr && pe_sel == 1'(p) && pwdata[13:0] == id_of(3'(s));
        end
      end

      // pending and active bits form the four states
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // every state inactive out of reset
          pend_q[p] <= '0;
          act_q[p] <= '0;
        end else begin
          for (int s = 0; s < NSRC; s++) begin
            // edge holds until ack; level follows the line
            // only this core's copy clears on its ack
            if (lvl_m[s]) pend_q[p][s] <= lvl[s];
            else pend_q[p][s] <= set_e[s] | (pend_q[p][s] & ~ack_s[s]);
            // others stay active until end of interrupt
            if (s == isp_pkg::S_LPI) act_q[p][s] <= 1'b0;
            else act_q[p][s] <= ack_s[s] | (act_q[p][s] & ~eoi_s[s]);
          end
        end
      end

      // priority view: group priority, running priority, best candidate
      always_comb begin
        logic [7:0] bp;
        logic [7:0] rv;
        logic [2:0] bs;
        logic bv;
        rv = isp_pkg::PRIO_IDLE;
        bs = 3'h0;
        bv = 1'b0;
        bp = isp_pkg::PRIO_IDLE;
        for (int s = 0; s < NSRC; s++) begin
          if (s == isp_pkg::S_LPI) begin
            prio[s] = lpi_cfg_q[7:0];
            // forced to non-secure group 1 with two security states
            grp[s] = two_sec_q ? isp_pkg::GRP_NS1 : lpi_cfg_q[9:8];
          end else begin
            prio[s] = prio_q[8*s +: 8];
            grp[s] = group_q[2*s +: 2];
          end
          if (grp[s] == isp_pkg::GRP_G0) gp[s] = prio[s] & (isp_pkg::MASK_ALL << bpr_q[p][2:0]);
          else gp[s] = prio[s] & (isp_pkg::MASK_ALL << bpr_q[p][isp_pkg::BPR1_LSB +: 3]);
          // lowest group priority among active slots
          if (act_q[p][s] && gp[s] < rv) rv = gp[s];
        end
        for (int s = 0; s < NSRC; s++) begin
          // active slots are not offered again
          // mask, preemption group and running priority all checked
          if (enable_q[s] && pend_q[p][s] && !act_q[p][s] && prio[s] < pmr_q[p] && gp[s] < rv && prio[s] < bp) begin
            bp = prio[s];
            bs = 3'(s);
            bv = 1'b1;
          end
          st_w[p][2*s +: 2] = isp_pkg::isp_istate_t'({act_q[p][s], pend_q[p][s]});
        end
        rpr_w[p] = rv;
        best_src_w[p] = bs;
        best_vld_w[p] = bv;
      end

      // interrupt line per core
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_q[p] <= 1'b0;
        else irq_q[p] <= best_vld_w[p];
      end
      assign irq_out[p] = irq_q[p];

      sequence s_lpi_ack;
        ack_do && ack_pe_q == 1'(p) && ack_src_q == 3'(isp_pkg::S_LPI) && !set_e[isp_pkg::S_LPI];
      endsequence
      sequence s_edge_ack;
        ack_do && ack_pe_q == 1'(p) && !lvl_m[ack_src_q] && ack_src_q != 3'(isp_pkg::S_LPI) && !set_e[ack_src_q];
      endsequence

      a_idle_rpr: assert property (act_q[p] == '0 |-> rpr_w[p] == isp_pkg::PRIO_IDLE)
        else $error("running priority not idle");
      a_lpi_no_active: assert property (!act_q[p][isp_pkg::S_LPI])
        else $error("locality slot went active");
      a_lpi_ack_clear: assert property (s_lpi_ack |=> !pend_q[p][isp_pkg::S_LPI])
        else $error("locality slot still pending after ack");
      a_ack_activates: assert property (s_edge_ack |=>
        act_q[p][$past(ack_src_q)] && !pend_q[p][$past(ack_src_q)]) else $error("acknowledge did not activate");
      a_edge_holds: assert property (trig_q[0] && pend_q[p][isp_pkg::S_PPI] && !ack_s[isp_pkg::S_PPI]
        |=> pend_q[p][isp_pkg::S_PPI]) else $error("edge pending lost");
      a_level_follow: assert property (!trig_q[0] ##1 !trig_q[0] |->
        pend_q[p][isp_pkg::S_PPI] == $past(pin_f_q[p])) else $error("level pending does not follow line");
      a_active_hidden: assert property (best_vld_w[p] |-> !act_q[p][best_src_w[p]])
        else $error("active interrupt offered again");
      a_reset_idle: assert property (!first_q |-> pend_q[p] == '0 && act_q[p] == '0 && !irq_q[p])
        else $error("state not idle after reset");
    end
  endgenerate

  a_sgi_per_pe: assert property (ack_do && ack_src_q == 3'(isp_pkg::S_SGI) && pend_q[~ack_pe_q][isp_pkg::S_SGI]
    |=> pend_q[~$past(ack_pe_q)][isp_pkg::S_SGI]) else $error("other core lost its copy");
  a_spi_one_core: assert property ($onehot0(tgt_w[0]) && $onehot0(tgt_w[1]))
    else $error("shared interrupt aimed at two cores");
endmodule
`default_nettype wire

// ### rtl/isp_pkg.sv
package isp_pkg;
  // sizes of the core
  localparam int NPE = 2;
  localparam int NSPI = 2;
  localparam int NSRC = 5;
  // per-core source slots
  localparam int S_SGI = 0;
  localparam int S_PPI = 1;
  localparam int S_SPI0 = 2;
  localparam int S_LPI = 4;
  // interrupt identifiers
  localparam logic [13:0] ID_SGI = 14'h0000;
  localparam logic [13:0] ID_PPI = 14'h0010;
  localparam logic [13:0] ID_SPI0 = 14'h0020;
  localparam logic [13:0] ID_LPI = 14'h2000;
  localparam logic [13:0] ID_SPURIOUS = 14'h03FF;
  localparam logic [7:0] PRIO_IDLE = 8'hFF;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  // groups
  localparam logic [1:0] GRP_G0 = 2'h0;
  localparam logic [1:0] GRP_S1 = 2'h1;
  localparam logic [1:0] GRP_NS1 = 2'h2;
  // global register offsets
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_GROUP = 12'h004;
  localparam logic [11:0] A_TRIG = 12'h008;
  localparam logic [11:0] A_ROUTE = 12'h00C;
  localparam logic [11:0] A_PRIO = 12'h010;
  localparam logic [11:0] A_SGI_GEN = 12'h014;
  localparam logic [11:0] A_ENABLE = 12'h018;
  localparam logic [11:0] A_LPI_CFG = 12'h01C;
  // per-core register bank: region 1, one core per 0x20
  localparam logic [5:0] PE_REGION = 6'h01;
  localparam logic [4:0] O_PMR = 5'h00;
  localparam logic [4:0] O_BPR = 5'h04;
  localparam logic [4:0] O_ACK = 5'h08;
  localparam logic [4:0] O_EOI = 5'h0C;
  localparam logic [4:0] O_RPR = 5'h10;
  localparam logic [4:0] O_STATE = 5'h14;
  // field positions
  localparam int F_AFF = 0;
  localparam int F_TWO_SEC = 1;
  localparam int RT_MODE = 0;
  localparam int RT_PE = 1;
  localparam int RT_TGT = 2;
  localparam int RT_STRIDE = 8;
  localparam int BPR1_LSB = 4;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [7:0] PMR_RST = 8'h00;
  localparam logic [6:0] BPR_RST = 7'h00;
  // message write addresses
  localparam logic [31:0] MSG_SPI_SET = 32'h0000_1040;
  localparam logic [31:0] MSG_SPI_CLR = 32'h0000_1048;
  localparam logic [31:0] MSG_LPI_BASE = 32'h0001_0040;
  localparam logic [31:0] MSG_LPI_STRIDE = 32'h0000_0100;

  typedef enum logic [1:0] {
    IST_INACTIVE = 2'b00,
    IST_PENDING = 2'b01,
    IST_ACTIVE = 2'b10,
    IST_ACT_PEND = 2'b11
  } isp_istate_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [15:0] data;
  } isp_msg_t;
endpackage

// ### verif/interrupt_state_and_priority_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_state_and_priority_core_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] e;
    logic err;
  } isp_row_t;
  localparam logic [11:0] P0 = 12'h040;
  localparam logic [11:0] P1 = 12'h060;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [isp_pkg::NPE-1:0] pin_private;
  logic [isp_pkg::NSPI-1:0] pin_shared;
  isp_pkg::isp_msg_t msg;
  logic [isp_pkg::NPE-1:0] irq_out;
  logic [31:0] rd;
  logic er;
  int error_cnt;
  int samples_checked;
  int hits;
  int wt;
  isp_row_t rows [15];
`define CHK(nm, e, s) check(nm, e, s)

  isp_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_private(pin_private), .pin_shared(pin_shared), .msg(msg), .irq_out(irq_out));
  isp_far_model far_end (.pclk(pclk), .pin_private(pin_private), .pin_shared(pin_shared), .msg(msg));

  // free running 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access cycles counted for the caller; only the watchdog ends a hang
    wt = 0;
    do begin
      @(posedge pclk);
      wt++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd);
  endtask

  function automatic logic [11:0] ca(input int p, input logic [4:0] o);
    return (p == 0 ? P0 : P1) + {7'h00, o};
  endfunction

  // acknowledge then end the interrupt on one core
  task automatic ae(input int p, input logic [13:0] id, input string nm);
    rdc(ca(p, isp_pkg::O_ACK), {18'h0, id}, nm);
    wr(ca(p, isp_pkg::O_EOI), {18'h0, id});
  endtask

  // bounded wait of up to 30 cycles; the level is compared here afterwards
  task automatic wait_irq(input int p, input logic v);
    int n;
    n = 0;
    while (irq_out[p] !== v && n < 30) begin
      @(posedge pclk);
      n++;
    end
    `CHK("irq wait", {31'h0, v}, {31'h0, irq_out[p]});
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // reset values read back, unmapped hole included
  task automatic row_pass();
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK($sformatf("row %0d data", i), rows[i].e, rd);
      `CHK($sformatf("row %0d err", i), {31'h0, rows[i].err}, {31'h0, er});
      `CHK($sformatf("row %0d wait", i), 32'h1, wt);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rows = '{
      '{isp_pkg::A_CTRL, {30'h0, isp_pkg::CTRL_RST}, 1'b0}, '{isp_pkg::A_GROUP, 32'h0, 1'b0},
      '{isp_pkg::A_TRIG, 32'h0, 1'b0}, '{isp_pkg::A_ROUTE, 32'h0, 1'b0},
      '{isp_pkg::A_PRIO, 32'h0, 1'b0}, '{isp_pkg::A_ENABLE, 32'h0, 1'b0},
      '{isp_pkg::A_LPI_CFG, 32'h0, 1'b0}, '{P0 + {7'h00, isp_pkg::O_PMR}, {24'h0, isp_pkg::PMR_RST}, 1'b0},
      '{P1 + {7'h00, isp_pkg::O_BPR}, {25'h0, isp_pkg::BPR_RST}, 1'b0},
      '{P0 + {7'h00, isp_pkg::O_RPR}, {24'h0, isp_pkg::PRIO_IDLE}, 1'b0},
      '{P1 + {7'h00, isp_pkg::O_RPR}, {24'h0, isp_pkg::PRIO_IDLE}, 1'b0},
      '{P0 + {7'h00, isp_pkg::O_STATE}, 32'h0, 1'b0}, '{P1 + {7'h00, isp_pkg::O_STATE}, 32'h0, 1'b0},
      '{P1 + {7'h00, isp_pkg::O_ACK}, {18'h0, isp_pkg::ID_SPURIOUS}, 1'b0}, '{12'h0F0, 32'h0, 1'b1}};
    do_reset();
    row_pass();
    // distinct priorities per slot, everything enabled and unmasked
    wr(isp_pkg::A_PRIO, 32'h4030_2010);
    wr(isp_pkg::A_ENABLE, 32'h0000_001F);
    wr(isp_pkg::A_LPI_CFG, 32'h0000_0050);
    wr(ca(0, isp_pkg::O_PMR), 32'h0000_00FF);
    wr(ca(1, isp_pkg::O_PMR), 32'h0000_00FF);
    // software interrupt to both cores, then raised again on core 0 while active
    wr(isp_pkg::A_SGI_GEN, 32'h0000_0003);
    wait_irq(1, 1'b1);
    `CHK("irq1 sgi", 32'h1, {31'h0, irq_out[1]});
    rdc(ca(0, isp_pkg::O_ACK), {18'h0, isp_pkg::ID_SGI}, "ack0 sgi");
    rdc(ca(0, isp_pkg::O_STATE), 32'h2, "state0 active");
    rdc(ca(1, isp_pkg::O_STATE), 32'h1, "state1 pending");
    rdc(ca(0, isp_pkg::O_RPR), 32'h10, "rpr0 sgi");
    wr(isp_pkg::A_SGI_GEN, 32'h0000_0001);
    rdc(ca(0, isp_pkg::O_STATE), 32'h3, "state0 act pend");
    `CHK("irq0 held", 32'h0, {31'h0, irq_out[0]});
    wr(ca(0, isp_pkg::O_EOI), {18'h0, isp_pkg::ID_SGI});
    wait_irq(0, 1'b1);
    `CHK("irq0 again", 32'h1, {31'h0, irq_out[0]});
    ae(0, isp_pkg::ID_SGI, "ack0 sgi2");
    ae(1, isp_pkg::ID_SGI, "ack1 sgi");
    rdc(ca(0, isp_pkg::O_RPR), {24'h0, isp_pkg::PRIO_IDLE}, "rpr0 idle");
    // short edge on core 0 private line, priority equal to mask first
    wr(isp_pkg::A_TRIG, 32'h1);
    wr(ca(0, isp_pkg::O_PMR), 32'h0000_0020);
    far_end.line(1'b0, 0, 1'b1);
    repeat (6) @(posedge pclk);
    far_end.line(1'b0, 0, 1'b0);
    rdc(ca(0, isp_pkg::O_STATE), 32'h4, "state0 ppi edge");
    rdc(ca(1, isp_pkg::O_STATE), 32'h0, "state1 no ppi");
    `CHK("irq0 at mask", 32'h0, {31'h0, irq_out[0]});
    wr(ca(0, isp_pkg::O_PMR), 32'h0000_0021);
    wait_irq(0, 1'b1);
    `CHK("irq0 above mask", 32'h1, {31'h0, irq_out[0]});
    ae(0, isp_pkg::ID_PPI, "ack0 ppi");
    // level private line on core 1 follows its source
    wr(isp_pkg::A_TRIG, 32'h0);
    far_end.line(1'b0, 1, 1'b1);
    wait_irq(1, 1'b1);
    `CHK("irq1 level", 32'h1, {31'h0, irq_out[1]});
    far_end.line(1'b0, 1, 1'b0);
    wait_irq(1, 1'b0);
    rdc(ca(1, isp_pkg::O_STATE), 32'h0, "state1 level gone");
    // shared level line routed to core 1 alone
    wr(isp_pkg::A_ROUTE, 32'h0000_0002);
    far_end.line(1'b1, 0, 1'b1);
    wait_irq(1, 1'b1);
    `CHK("irq0 spi0 off", 32'h0, {31'h0, irq_out[0]});
    rdc(ca(1, isp_pkg::O_ACK), {18'h0, isp_pkg::ID_SPI0}, "ack1 spi0");
    rdc(ca(1, isp_pkg::O_STATE), 32'h30, "state1 spi act pend");
    far_end.line(1'b1, 0, 1'b0);
    repeat (6) @(posedge pclk);
    rdc(ca(1, isp_pkg::O_STATE), 32'h20, "state1 spi active");
    wr(ca(1, isp_pkg::O_EOI), {18'h0, isp_pkg::ID_SPI0});
    // one-of-N edge raised by message write
    wr(isp_pkg::A_ROUTE, 32'h0000_0100);
    wr(isp_pkg::A_TRIG, 32'h4);
    far_end.send(isp_pkg::MSG_SPI_SET, 16'h0001);
    hits = 0;
    repeat (8) begin
      @(posedge pclk);
      if (irq_out === 2'b11) hits++;
    end
    `CHK("one of n both", 32'h0, hits);
    apb(1'b0, ca(0, isp_pkg::O_ACK), 32'h0);
    hits = (rd === {18'h0, isp_pkg::ID_SPI0} + 32'h1) ? 1 : 0;
    apb(1'b0, ca(1, isp_pkg::O_ACK), 32'h0);
    hits += (rd === {18'h0, isp_pkg::ID_SPI0} + 32'h1) ? 1 : 0;
    `CHK("one of n taken", 32'h1, hits);
    wr(ca(0, isp_pkg::O_EOI), {18'h0, isp_pkg::ID_SPI0} + 32'h1);
    wr(ca(1, isp_pkg::O_EOI), {18'h0, isp_pkg::ID_SPI0} + 32'h1);
    // locality message to core 1 leaves no active state
    far_end.send(isp_pkg::MSG_LPI_BASE + isp_pkg::MSG_LPI_STRIDE, 16'h0000);
    wait_irq(1, 1'b1);
    `CHK("irq0 lpi off", 32'h0, {31'h0, irq_out[0]});
    rdc(ca(1, isp_pkg::O_ACK), {18'h0, isp_pkg::ID_LPI}, "ack1 lpi");
    rdc(ca(1, isp_pkg::O_STATE), 32'h0, "state1 lpi gone");
    rdc(ca(1, isp_pkg::O_RPR), {24'h0, isp_pkg::PRIO_IDLE}, "rpr1 lpi");
    // legacy routing, one target bit for core 1; left active across reset
    wr(isp_pkg::A_CTRL, 32'h2);
    wr(isp_pkg::A_ROUTE, 32'h0000_0008);
    far_end.line(1'b1, 0, 1'b1);
    wait_irq(1, 1'b1);
    `CHK("irq0 legacy off", 32'h0, {31'h0, irq_out[0]});
    rdc(ca(1, isp_pkg::O_ACK), {18'h0, isp_pkg::ID_SPI0}, "ack1 legacy");
    rdc(ca(1, isp_pkg::O_RPR), 32'h30, "rpr1 spi0");
    far_end.line(1'b1, 0, 1'b0);
    repeat (6) @(posedge pclk);
    // coarse binary point on core 0 stops a finer priority preempting
    wr(isp_pkg::A_PRIO, 32'h4030_1810);
    wr(ca(0, isp_pkg::O_BPR), 32'h0000_0005);
    far_end.line(1'b0, 0, 1'b1);
    wait_irq(0, 1'b1);
    rdc(ca(0, isp_pkg::O_ACK), {18'h0, isp_pkg::ID_PPI}, "ack0 ppi level");
    rdc(ca(0, isp_pkg::O_RPR), 32'h0, "rpr0 group prio");
    wr(isp_pkg::A_SGI_GEN, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    `CHK("irq0 no preempt", 32'h0, {31'h0, irq_out[0]});
    wr(ca(0, isp_pkg::O_BPR), 32'h0000_0000);
    wait_irq(0, 1'b1);
    `CHK("irq0 preempts", 32'h1, {31'h0, irq_out[0]});
    far_end.line(1'b0, 0, 1'b0);
    repeat (6) @(posedge pclk);
    do_reset();
    row_pass();
    complete_run();
  end
endmodule
`default_nettype wire

// ### verif/isp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// peripherals and message writers on the far side of the core
module isp_far_model (
  input wire logic pclk,
  output logic [isp_pkg::NPE-1:0] pin_private,
  output logic [isp_pkg::NSPI-1:0] pin_shared,
  output var isp_pkg::isp_msg_t msg
);
  // all sources quiet at time zero
  initial begin
    pin_private = '0;
    pin_shared = '0;
    msg = '{valid: 1'b0, addr: 32'h0, data: 16'h0};
  end

  // level set and cleared at source
  task automatic line(input logic shared, input int i, input logic v);
    @(posedge pclk);
    if (shared) begin
      pin_shared[i] <= v;
    end else begin
      pin_private[i] <= v;
    end
  endtask

  // write to assigned address
  // idle bus shows the inverse so a stale address never looks valid
  task automatic send(input logic [31:0] a, input logic [15:0] d);
    @(posedge pclk);
    msg <= '{valid: 1'b1, addr: a, data: d};
    @(posedge pclk);
    msg <= '{valid: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire
